// [design/crmdec_defines.svh]
`ifndef CRMDEC_DEFINES_SVH
`define CRMDEC_DEFINES_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define CRMDEC_CMD_READ        4'h0
`define CRMDEC_CMD_WRITE       4'h8
`define CRMDEC_CMD_PERIODIC    4'hB

// ----------------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------------
`define CRMDEC_GLOBAL_ADDR     4'h0
`define CRMDEC_NODE_REG_ADDR   8'h11
`define CRMDEC_PDC_EN_ADDR     8'h13
`define CRMDEC_PDC_EN_BIT      0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CRMDEC_NODE_RST        4'h0
`define CRMDEC_PDC_EN_RST      1'b0
`define CRMDEC_BYTE_ZERO       8'h00
`define CRMDEC_NIBBLE_ZERO     4'h0

`endif

// [design/crmdec_pkg.sv]
package crmdec_pkg;

	// ------------------------------------------------------------------
	// Frame carriers
	// ------------------------------------------------------------------
	// Received command, CRC already stripped
	typedef struct packed {
		logic [3:0] frame_node_address;
		logic [3:0] code;
		logic [7:0] register_byte_address;
		logic [7:0] data;
	} crmdec_cmd_t;

	// Reply before CRC and symbol coding
	typedef struct packed {
		logic [3:0] frame_node_address;
		logic [3:0] code;
		logic [7:0] data_hi;
		logic [7:0] data_lo;
	} crmdec_rsp_t;

	// Decoded action of one frame
	typedef struct packed {
		logic do_read;
		logic do_write;
		logic do_periodic;
		logic send_reply;
	} crmdec_action_t;

	// ------------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_WRITE  = 5'b00010,
		ST_RD_LO  = 5'b00100,
		ST_RD_HI  = 5'b01000,
		ST_REPLY  = 5'b10000
	} crmdec_state_t;

endpackage : crmdec_pkg

// [design/crmdec_classify.sv]
`timescale 1ns/1ps
`default_nettype none
`include "crmdec_defines.svh"

module crmdec_classify (
	input  wire crmdec_pkg::crmdec_cmd_t    cmd,
	input  wire logic [3:0]                 node_address,
	output var  crmdec_pkg::crmdec_action_t action
);
	import crmdec_pkg::*;

	logic own_hit;
	logic global_hit;
	logic global_node_wr;

	// ------------------------------------------------------------------
	// Address match
	// ------------------------------------------------------------------
	// Global address never counts as own, even while node is zero
	assign global_hit = (cmd.frame_node_address == `CRMDEC_GLOBAL_ADDR);
	assign own_hit    = !global_hit &&
	                    (cmd.frame_node_address == node_address);
	// Global write of the node register while still unassigned
	assign global_node_wr = global_hit &&
		(cmd.register_byte_address == `CRMDEC_NODE_REG_ADDR) &&
		(node_address == `CRMDEC_NODE_RST);

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	always_comb begin
		action = '0;
		unique case (cmd.code)
			`CRMDEC_CMD_READ: begin
				action.do_read    = own_hit;
				action.send_reply = own_hit;
			end
			`CRMDEC_CMD_WRITE: begin
				action.do_write   = own_hit || global_node_wr;
				action.send_reply = own_hit || global_node_wr;
			end
			`CRMDEC_CMD_PERIODIC: begin
				action.do_periodic = own_hit || global_hit;
				action.send_reply  = own_hit;
			end
			default: action = '0;
		endcase
	end

endmodule : crmdec_classify

`default_nettype wire

// [design/crmdec_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "crmdec_defines.svh"

module crmdec_top (
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	// Command frames from the receiver
	input  wire logic                    cmd_valid,
	output var  logic                    cmd_ready,
	input  wire crmdec_pkg::crmdec_cmd_t cmd_in,
	input  wire logic                    cmd_crc_ok,
	// Reply frames to the transmitter
	output var  logic                    rsp_valid,
	input  wire logic                    rsp_ready,
	output var  crmdec_pkg::crmdec_rsp_t rsp_out,
	// Register bank access
	output var  logic [7:0]              bank_addr,
	input  wire logic [7:0]              bank_rdata,
	input  wire logic                    bank_readable,
	input  wire logic                    bank_writable,
	output var  logic                    bank_wr_en,
	output var  logic [7:0]              bank_wdata,
	// Device state
	output var  logic [3:0]              node_address,
	output var  logic                    periodic_collection_mode
);
	import crmdec_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	crmdec_state_t  state_reg;
	crmdec_state_t  state_next;
	crmdec_cmd_t    cmd_reg;
	crmdec_cmd_t    cmd_next;
	crmdec_rsp_t    rsp_reg;
	crmdec_rsp_t    rsp_next;
	logic [7:0]     bank_addr_reg;
	logic [7:0]     bank_addr_next;
	logic           zero_reg;
	logic           zero_next;
	logic [3:0]     node_address_register;
	logic [3:0]     node_next;
	logic           periodic_collection_enable;
	logic           pdc_en_next;

	crmdec_action_t action;
	logic           accept;
	logic           hit_node;
	logic           hit_pdc;
	logic           rd_ok;
	logic           wr_ok;
	logic [7:0]     rd_byte;

	// ------------------------------------------------------------------
	// Frame classification
	// ------------------------------------------------------------------
	crmdec_classify u_classify (
		.cmd          (cmd_in),
		.node_address (node_address_register),
		.action       (action)
	);

	// Decode runs on the offered frame, so taking it costs no cycle
	// Only a complete frame with good CRC is acted on
	assign cmd_ready = (state_reg == ST_IDLE);
	assign accept    = cmd_valid && cmd_ready && cmd_crc_ok;

	// ------------------------------------------------------------------
	// Register access multiplexer
	// ------------------------------------------------------------------
	// Node address and periodic enable live here, all else in the bank
	// Bank flags are ignored for these two internal addresses
	assign hit_node = (bank_addr_reg == `CRMDEC_NODE_REG_ADDR);
	assign hit_pdc  = (bank_addr_reg == `CRMDEC_PDC_EN_ADDR);
	assign rd_ok    = hit_node || hit_pdc || bank_readable;
	assign wr_ok    = hit_node || hit_pdc || bank_writable;

	always_comb begin
		rd_byte = `CRMDEC_BYTE_ZERO;
		if (hit_node) begin
			rd_byte = {`CRMDEC_NIBBLE_ZERO, node_address_register};
		end else if (hit_pdc) begin
			rd_byte[`CRMDEC_PDC_EN_BIT] = periodic_collection_enable;
		end else if (bank_readable) begin
			rd_byte = bank_rdata;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer next state
	// ------------------------------------------------------------------
	always_comb begin
		state_next     = state_reg;
		cmd_next       = cmd_reg;
		rsp_next       = rsp_reg;
		bank_addr_next = bank_addr_reg;
		zero_next      = zero_reg;
		node_next      = node_address_register;
		pdc_en_next    = periodic_collection_enable;
		bank_wr_en     = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				zero_next = 1'b0;
				if (accept) begin
					// Keep the frame; the bank address starts from it
					cmd_next       = cmd_in;
					bank_addr_next = cmd_in.register_byte_address;
					if (action.do_periodic) begin
						pdc_en_next = 1'b1;
					end
					if (action.do_write) begin
						state_next = ST_WRITE;
					end else if (action.do_read) begin
						state_next = ST_RD_LO;
					end else if (action.send_reply) begin
						// Periodic reply carries no data
						rsp_next.frame_node_address = node_address_register;
						rsp_next.code    = cmd_in.code;
						rsp_next.data_hi = `CRMDEC_BYTE_ZERO;
						rsp_next.data_lo = `CRMDEC_BYTE_ZERO;
						state_next       = ST_REPLY;
					end
					// Anything else stays idle; only frame, bank address and periodic enable change
				end
			end
			ST_WRITE: begin
				// One-cycle strobe; internal registers bypass the bank
				if (hit_node) begin
					node_next = cmd_reg.data[3:0];
				end else if (hit_pdc) begin
					pdc_en_next = cmd_reg.data[`CRMDEC_PDC_EN_BIT];
				end else begin
					bank_wr_en = bank_writable;
				end
				// Unwritable target blanks both reply bytes
				zero_next  = !wr_ok;
				state_next = ST_RD_LO;
			end
			ST_RD_LO: begin
				// Read back after the write has landed
				rsp_next.data_lo = (zero_reg || !rd_ok) ?
				                   `CRMDEC_BYTE_ZERO : rd_byte;
				zero_next        = zero_reg || !rd_ok;
				bank_addr_next   = bank_addr_reg + 8'h01;
				state_next       = ST_RD_HI;
			end
			ST_RD_HI: begin
				// High byte is read from the next address up
				rsp_next.data_hi = zero_reg ?
				                   `CRMDEC_BYTE_ZERO : rd_byte;
				// Address field taken after any node address update
				rsp_next.frame_node_address = node_address_register;
				rsp_next.code = cmd_reg.code;
				state_next    = ST_REPLY;
			end
			ST_REPLY: begin
				// Reply stands until the transmitter takes it
				if (rsp_ready) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Sequencer registers
	// ------------------------------------------------------------------
	// Whole sequencer returns to idle with no reply pending
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg                  <= ST_IDLE;
			cmd_reg                    <= '0;
			rsp_reg                    <= '0;
			bank_addr_reg              <= `CRMDEC_BYTE_ZERO;
			zero_reg                   <= 1'b0;
			node_address_register      <= `CRMDEC_NODE_RST;
			periodic_collection_enable <= `CRMDEC_PDC_EN_RST;
		end else begin
			state_reg                  <= state_next;
			cmd_reg                    <= cmd_next;
			rsp_reg                    <= rsp_next;
			bank_addr_reg              <= bank_addr_next;
			zero_reg                   <= zero_next;
			node_address_register      <= node_next;
			periodic_collection_enable <= pdc_en_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign rsp_valid                = (state_reg == ST_REPLY);
	assign rsp_out                  = rsp_reg;
	assign bank_addr                = bank_addr_reg;
	// Write data straight from the captured frame
	assign bank_wdata               = cmd_reg.data;
	assign node_address             = node_address_register;
	assign periodic_collection_mode = periodic_collection_enable;

endmodule : crmdec_top

`default_nettype wire

// [tb/crmdec_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module crmdec_properties (
	input wire logic                    clk_sys,
	input wire logic                    rst,
	input wire logic                    cmd_valid,
	input wire logic                    cmd_ready,
	input wire crmdec_pkg::crmdec_cmd_t cmd_in,
	input wire logic                    cmd_crc_ok,
	input wire logic                    rsp_valid,
	input wire logic                    rsp_ready,
	input wire crmdec_pkg::crmdec_rsp_t rsp_out,
	input wire logic [7:0]              bank_addr,
	input wire logic [7:0]              bank_rdata,
	input wire logic                    bank_readable,
	input wire logic                    bank_writable,
	input wire logic                    bank_wr_en,
	input wire logic [7:0]              bank_wdata,
	input wire logic [3:0]              node_address,
	input wire logic                    periodic_collection_mode
);
	import crmdec_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic take;
	logic own;
	logic ext;
	logic [3:0] fa;
	logic [3:0] cd;
	// Good frame taken, own address, bank target
	assign take = cmd_valid && cmd_ready && cmd_crc_ok;
	assign fa = cmd_in.frame_node_address;
	assign cd = cmd_in.code;
	assign own = take && node_address != 4'h0 && fa == node_address;
	assign ext = cmd_in.register_byte_address != 8'h11
		&& cmd_in.register_byte_address != 8'h13;
	a_read_reply: assert property (
		own && cd == 4'h0 && ext |-> ##3 rsp_valid && rsp_out.code == 4'h0)
		else $error("read reply late or wrong code");
	a_unreadable_zero: assert property (
		own && cd == 4'h0 && ext ##1 !bank_readable
		|-> ##2 rsp_valid && {rsp_out.data_hi, rsp_out.data_lo} == 16'h0000)
		else $error("unreadable read gave data");
	a_write_strobe: assert property (
		own && cd == 4'h8 && ext |=> bank_wr_en == bank_writable
		&& bank_addr == $past(cmd_in.register_byte_address)
		&& bank_wdata == $past(cmd_in.data))
		else $error("write strobe wrong");
	a_write_reply: assert property (
		own && cd == 4'h8 |-> ##4 rsp_valid && rsp_out.code == 4'h8)
		else $error("write reply late or wrong code");
	a_foreign_drop: assert property (
		take && fa != node_address && fa != 4'h0 |=> cmd_ready && !rsp_valid)
		else $error("foreign frame answered");
	a_unknown_code: assert property (
		take && !(cd inside {4'h0, 4'h8, 4'hB})
		|=> cmd_ready && !rsp_valid && !bank_wr_en)
		else $error("unknown code acted on");
	a_bad_crc: assert property (
		cmd_valid && cmd_ready && !cmd_crc_ok |=> cmd_ready && !rsp_valid)
		else $error("bad frame acted on");
	a_periodic_own: assert property (
		own && cd == 4'hB |=> rsp_valid && periodic_collection_mode
		&& rsp_out.code == 4'hB)
		else $error("addressed periodic wrong");
	a_periodic_glob: assert property (
		take && fa == 4'h0 && cd == 4'hB
		|=> periodic_collection_mode && !rsp_valid)
		else $error("global periodic wrong");
	a_reply_addr: assert property (
		$rose(rsp_valid) |-> rsp_out.frame_node_address == node_address)
		else $error("reply address wrong");
	a_reply_hold: assert property (
		rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_out))
		else $error("reply dropped before taken");
	c_read: cover property (own && cd == 4'h0);
	c_write: cover property (own && cd == 4'h8);
	c_periodic: cover property (take && cd == 4'hB);
endmodule : crmdec_properties
bind crmdec_top crmdec_properties chk_u (
	.clk_sys                  (clk_sys),
	.rst                      (rst),
	.cmd_valid                (cmd_valid),
	.cmd_ready                (cmd_ready),
	.cmd_in                   (cmd_in),
	.cmd_crc_ok               (cmd_crc_ok),
	.rsp_valid                (rsp_valid),
	.rsp_ready                (rsp_ready),
	.rsp_out                  (rsp_out),
	.bank_addr                (bank_addr),
	.bank_rdata               (bank_rdata),
	.bank_readable            (bank_readable),
	.bank_writable            (bank_writable),
	.bank_wr_en               (bank_wr_en),
	.bank_wdata               (bank_wdata),
	.node_address             (node_address),
	.periodic_collection_mode (periodic_collection_mode)
);
`default_nettype wire

// [tb/crmdec_bank_model.sv]
`timescale 1ns/1ps
`default_nettype none
module crmdec_bank_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] bank_addr,
	output var  logic [7:0] bank_rdata,
	output var  logic       bank_readable,
	output var  logic       bank_writable,
	input  wire logic       bank_wr_en,
	input  wire logic [7:0] bank_wdata
);
	logic [7:0] mem [256];
	// Pattern fill the bench can recompute
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
	end
	// Low quarter readable, low eighth writable
	assign bank_readable = bank_addr < 8'h40;
	assign bank_writable = bank_addr < 8'h20;
	assign bank_rdata = mem[bank_addr];
	// Store on the write strobe
	always @(posedge clk_sys) begin
		if (bank_wr_en && bank_writable) mem[bank_addr] <= bank_wdata;
	end
endmodule : crmdec_bank_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	import crmdec_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        cmd_valid = 1'b0;
	logic        cmd_crc_ok = 1'b0;
	logic        rsp_ready = 1'b0;
	logic        cmd_ready, rsp_valid, bank_readable, bank_writable;
	logic        bank_wr_en, periodic_collection_mode;
	logic [7:0]  bank_addr, bank_rdata, bank_wdata;
	logic [3:0]  node_address;
	crmdec_cmd_t cmd_in = '0;
	crmdec_rsp_t rsp_out;
	int          fails = 0;
	int          samples_checked = 0;
	// Clock and instances
	always #2 clk_sys = ~clk_sys;
	crmdec_top dut_u (
		.clk_sys                  (clk_sys),
		.rst                      (rst),
		.cmd_valid                (cmd_valid),
		.cmd_ready                (cmd_ready),
		.cmd_in                   (cmd_in),
		.cmd_crc_ok               (cmd_crc_ok),
		.rsp_valid                (rsp_valid),
		.rsp_ready                (rsp_ready),
		.rsp_out                  (rsp_out),
		.bank_addr                (bank_addr),
		.bank_rdata               (bank_rdata),
		.bank_readable            (bank_readable),
		.bank_writable            (bank_writable),
		.bank_wr_en               (bank_wr_en),
		.bank_wdata               (bank_wdata),
		.node_address             (node_address),
		.periodic_collection_mode (periodic_collection_mode)
	);
	crmdec_bank_model bank_u (
		.clk_sys       (clk_sys),
		.bank_addr     (bank_addr),
		.bank_rdata    (bank_rdata),
		.bank_readable (bank_readable),
		.bank_writable (bank_writable),
		.bank_wr_en    (bank_wr_en),
		.bank_wdata    (bank_wdata)
	);
	function automatic logic [7:0] pat(logic [7:0] a);
		return a ^ 8'h5A;
	endfunction : pat
	task automatic check(string what, logic [23:0] exp, logic [23:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic reset_dut;
		rst = 1'b1;
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
	endtask : reset_dut
	task automatic send(logic [3:0] a, logic [3:0] c, logic [7:0] ra,
		logic [7:0] d, logic ok);
		@(negedge clk_sys);
		cmd_in = {a, c, ra, d};
		cmd_crc_ok = ok;
		cmd_valid = 1'b1;
		for (int n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge clk_sys);
		check("cmd ready", 24'h1, {23'h0, cmd_ready});
		@(negedge clk_sys);
		cmd_valid = 1'b0;
	endtask : send
	task automatic reply(string what, logic [23:0] exp);
		for (int n = 0; n < 20 && rsp_valid !== 1'b1; n++) @(negedge clk_sys);
		check({what, " valid"}, 24'h1, {23'h0, rsp_valid});
		check(what, exp, rsp_out);
		// Leave the reply waiting one cycle to prove it stands
		@(negedge clk_sys);
		check({what, " held"}, exp, rsp_out);
		rsp_ready = 1'b1;
		@(negedge clk_sys);
		rsp_ready = 1'b0;
	endtask : reply
	task automatic none(string what);
		logic seen;
		seen = 1'b0;
		repeat (6) begin
			@(negedge clk_sys);
			seen = seen | rsp_valid;
		end
		check(what, 24'h0, {23'h0, seen});
	endtask : none
	task automatic t_assign;
		send(4'h0, 4'h8, 8'h11, 8'h05, 1'b1);
		reply("node assign", {4'h5, 4'h8, pat(8'h12), 8'h05});
		check("node", 24'h5, {20'h0, node_address});
		$display("test assign done");
	endtask : t_assign
	task automatic t_read;
		send(4'h5, 4'h0, 8'h20, 8'h00, 1'b1);
		reply("read", {4'h5, 4'h0, pat(8'h21), pat(8'h20)});
		send(4'h5, 4'h0, 8'h80, 8'h00, 1'b1);
		reply("unreadable", {4'h5, 4'h0, 16'h0000});
		send(4'h3, 4'h0, 8'h20, 8'h00, 1'b1);
		none("foreign read");
		send(4'h0, 4'h0, 8'h20, 8'h00, 1'b1);
		none("global read");
		$display("test read done");
	endtask : t_read
	task automatic t_write;
		send(4'h3, 4'h8, 8'h04, 8'hFF, 1'b1);
		none("foreign write");
		send(4'h0, 4'h8, 8'h04, 8'hFF, 1'b1);
		none("global write");
		send(4'h0, 4'h8, 8'h11, 8'h09, 1'b1);
		none("global node write");
		check("node kept", 24'h5, {20'h0, node_address});
		send(4'h5, 4'h8, 8'h04, 8'hA5, 1'b1);
		reply("write", {4'h5, 4'h8, pat(8'h05), 8'hA5});
		send(4'h5, 4'h8, 8'h30, 8'h77, 1'b1);
		reply("unwritable", {4'h5, 4'h8, 16'h0000});
		$display("test write done");
	endtask : t_write
	task automatic t_codes;
		for (int c = 1; c < 16; c++) begin
			if (c != 8 && c != 11) begin
				send(4'h5, 4'(c), 8'h04, 8'h3C, 1'b1);
				none("unknown code");
			end
		end
		send(4'h5, 4'h8, 8'h04, 8'h11, 1'b0);
		none("bad crc");
		send(4'h5, 4'h0, 8'h04, 8'h00, 1'b1);
		reply("unchanged", {4'h5, 4'h0, pat(8'h05), 8'hA5});
		$display("test codes done");
	endtask : t_codes
	task automatic t_periodic;
		send(4'h5, 4'hB, 8'h00, 8'h00, 1'b1);
		reply("periodic", {4'h5, 4'hB, 16'h0000});
		check("mode", 24'h1, {23'h0, periodic_collection_mode});
		send(4'h5, 4'h0, 8'h12, 8'h00, 1'b1);
		reply("enable read", {4'h5, 4'h0, 8'h01, pat(8'h12)});
		reset_dut();
		check("mode rst", 24'h0, {23'h0, periodic_collection_mode});
		send(4'h0, 4'hB, 8'h00, 8'h00, 1'b1);
		none("global periodic");
		check("mode glob", 24'h1, {23'h0, periodic_collection_mode});
		$display("test periodic done");
	endtask : t_periodic
	task automatic end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test
	// Main sequence
	initial begin
		reset_dut();
		t_assign();
		t_read();
		t_write();
		t_codes();
		t_periodic();
		end_of_test();
	end
	// Watchdog, far above the roughly 250 cycles the tests need
	initial begin
		#(4 * 5000);
		fails++;
		end_of_test();
	end
endmodule : tb
`default_nettype wire
